/* File: logic/bdag_pkg.sv */
package bdag_pkg;

  // ***************************************************************
  // address geometry
  // ***************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned PMEM_W = 10;
  localparam int unsigned BIT_W = 2;

  // ***************************************************************
  // memory banks that the select register may hold
  // ***************************************************************
  localparam logic [3:0] BANK_SRAM = 4'h0;
  localparam logic [3:0] BANK_NV = 4'h4;
  localparam logic [3:0] BANK_PERIPH = 4'hf;

  // ***************************************************************
  // populated regions
  // ***************************************************************
  localparam logic [11:0] SRAM_LO = 12'h000;
  localparam logic [11:0] SRAM_HI = 12'h07f;
  localparam logic [11:0] NV_LO = 12'h400;
  localparam logic [11:0] NV_HI = 12'h43f;
  localparam logic [11:0] PERIPH_LO = 12'hf80;
  localparam logic [11:0] PERIPH_HI = 12'hfff;

  // special-area bit addressing windows (upper nibble of the low byte)
  localparam logic [3:0] FMEM_INTR_NIB = 4'hb;
  localparam logic [3:0] FMEM_PORT_NIB = 4'hf;
  // pointer-indexed peripheral window: upper six address bits all ones
  localparam logic [5:0] PMEM_TOP = 6'h3f;

  // reset values and the one-nibble pointer step
  localparam logic RST_FLAG = 1'b0;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [3:0] ONE_NIB = 4'h1;

  // ***************************************************************
  // addressing modes
  // ***************************************************************
  typedef enum logic [3:0] {
    MODE_DIRECT = 4'h0,
    MODE_BIT_DIRECT = 4'h1,
    MODE_PTR_MAIN = 4'h2,
    MODE_PTR_MAIN_INC = 4'h3,
    MODE_PTR_MAIN_DEC = 4'h4,
    MODE_PTR_ALT_A = 4'h5,
    MODE_PTR_ALT_B = 4'h6,
    MODE_BIT_SPECIAL = 4'h7,
    MODE_BIT_PTR_PERIPH = 4'h8,
    MODE_BIT_PTR_HIGH = 4'h9,
    MODE_STACK = 4'ha
  } bdag_mode_e;

  // instruction classes driving an access
  typedef enum logic [3:0] {
    INS_MOVE = 4'h0,
    INS_EXCHANGE = 4'h1,
    INS_INCR_SKIP = 4'h2,
    INS_INPUT = 4'h3,
    INS_OUTPUT = 4'h4,
    INS_BIT_SET = 4'h5,
    INS_BIT_CLEAR = 4'h6,
    INS_SKIP_TRUE = 4'h7,
    INS_SKIP_FALSE = 4'h8,
    INS_COMPARE_SKIP = 4'h9,
    INS_BIT_LOGIC = 4'ha,
    INS_STACK_OP = 4'hb,
    INS_OTHER = 4'hc
  } bdag_instr_e;

  // decoded target region
  typedef enum logic [1:0] {
    REG_NONE = 2'h0,
    REG_SRAM = 2'h1,
    REG_NV = 2'h2,
    REG_PERIPH = 2'h3
  } bdag_region_e;

endpackage : bdag_pkg

/* File: logic/bdag_bank_if.sv */
`timescale 1ns/10ps
interface bdag_bank_if;
  logic bank_enable_flag;
  logic [3:0] bank_select_reg;
  logic [3:0] active_bank;

  modport ctl (
    output bank_enable_flag,
    output bank_select_reg,
    output active_bank
  );
  modport user (
    input bank_enable_flag,
    input bank_select_reg,
    input active_bank
  );
endinterface : bdag_bank_if

/* File: logic/bdag_region_dec.sv */
`timescale 1ns/10ps
module bdag_region_dec (
  input wire logic [11:0] i_addr,
  output bdag_pkg::bdag_region_e o_region
);

  // ***************************************************************
  // region classification
  // ***************************************************************
  // holes between regions decode to none so arrays stay untouched
  wire in_sram = (i_addr >= bdag_pkg::SRAM_LO) && (i_addr <= bdag_pkg::SRAM_HI);
  wire in_nv = (i_addr >= bdag_pkg::NV_LO) && (i_addr <= bdag_pkg::NV_HI);
  wire in_periph = (i_addr >= bdag_pkg::PERIPH_LO) && (i_addr <= bdag_pkg::PERIPH_HI);

  assign o_region = in_sram ? bdag_pkg::REG_SRAM :
                    in_nv ? bdag_pkg::REG_NV :
                    in_periph ? bdag_pkg::REG_PERIPH : bdag_pkg::REG_NONE;

endmodule : bdag_region_dec

/* File: logic/bdag_bank_ctl.sv */
`timescale 1ns/10ps
module bdag_bank_ctl #(
  parameter int unsigned FLAG_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_flag_set,
  input wire logic i_flag_clr,
  input wire logic i_sel_load,
  input wire logic [3:0] i_sel_val,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_int_entry,
  input wire logic i_int_flag_val,
  input wire logic i_int_ret,
  output logic o_sel_refused,
  bdag_bank_if.ctl bank
);

  // ***************************************************************
  // parameter check
  // ***************************************************************
  generate
    if (FLAG_DEPTH < 2) begin : g_bad_depth
      $error("bdag_bank_ctl: FLAG_DEPTH must be at least 2");
    end
  endgenerate

  logic flag;
  logic [3:0] sel;
  logic [FLAG_DEPTH-1:0] saved;

  // only banks 0, 4 and 15 are accepted
  wire sel_ok = (i_sel_val == bdag_pkg::BANK_SRAM) || (i_sel_val == bdag_pkg::BANK_NV) ||
                (i_sel_val == bdag_pkg::BANK_PERIPH);
  wire push = i_call | i_int_entry;
  wire pop = (i_ret | i_int_ret) & ~push;

  // entry wins over return, returns win over bit set or clear
  wire next_flag = i_int_entry ? i_int_flag_val :
                   i_call ? flag :
                   pop ? saved[0] :
                   i_flag_set ? 1'b1 :
                   i_flag_clr ? 1'b0 : flag;

  // ***************************************************************
  // flag, select and flag save stack
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag <= bdag_pkg::RST_FLAG;
      saved <= '0;
    end else begin
      flag <= next_flag;
      if (push) begin
        saved <= {saved[FLAG_DEPTH-2:0], flag};
      end else if (pop) begin
        saved <= {1'b0, saved[FLAG_DEPTH-1:1]};
      end
    end
  end

  // select is loaded only by the bank select instruction
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel <= bdag_pkg::RST_SEL;
      o_sel_refused <= 1'b0;
    end else begin
      o_sel_refused <= i_sel_load & ~sel_ok;
      if (i_sel_load && sel_ok) begin
        sel <= i_sel_val;
      end
    end
  end

  assign bank.bank_enable_flag = flag;
  assign bank.bank_select_reg = sel;
  assign bank.active_bank = flag ? sel : bdag_pkg::BANK_SRAM;

endmodule : bdag_bank_ctl

/* File: logic/bdag_top.sv */
`timescale 1ns/10ps
module bdag_top #(
  parameter int unsigned FLAG_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic [3:0] i_mode,
  input wire logic [3:0] i_instr,
  input wire logic i_byte,
  input wire logic [9:0] i_operand,
  input wire logic [1:0] i_bit,
  input wire logic [3:0] i_ptr_high,
  input wire logic [3:0] i_ptr_low,
  input wire logic [7:0] i_alt_pointer_pair_a,
  input wire logic [7:0] i_alt_pointer_pair_b,
  input wire logic [7:0] i_stack_ptr,
  input wire logic i_flag_set,
  input wire logic i_flag_clr,
  input wire logic i_sel_load,
  input wire logic [3:0] i_sel_val,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_int_entry,
  input wire logic i_int_flag_val,
  input wire logic i_int_ret,
  output logic o_addr_valid,
  output logic [11:0] o_addr,
  output logic o_pair,
  output logic [11:0] o_addr_pair,
  output logic [1:0] o_bit_num,
  output logic [1:0] o_region,
  output logic o_refused,
  output logic o_ptr_low_wr,
  output logic [3:0] o_ptr_low_next,
  output logic o_sel_refused,
  output logic o_bank_enable_flag,
  output logic [3:0] o_bank_select_reg
);

  // ***************************************************************
  // bank flag and select register
  // ***************************************************************
  bdag_bank_if bank_bus ();

  bdag_bank_ctl #(
    .FLAG_DEPTH(FLAG_DEPTH)
  ) u_bank (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_flag_set(i_flag_set),
    .i_flag_clr(i_flag_clr),
    .i_sel_load(i_sel_load),
    .i_sel_val(i_sel_val),
    .i_call(i_call),
    .i_ret(i_ret),
    .i_int_entry(i_int_entry),
    .i_int_flag_val(i_int_flag_val),
    .i_int_ret(i_int_ret),
    .o_sel_refused(o_sel_refused),
    .bank(bank_bus.ctl)
  );

  // ***************************************************************
  // mode and instruction decode
  // ***************************************************************
  wire m_direct = (i_mode == bdag_pkg::MODE_DIRECT);
  wire m_bit_dir = (i_mode == bdag_pkg::MODE_BIT_DIRECT);
  wire m_inc = (i_mode == bdag_pkg::MODE_PTR_MAIN_INC);
  wire m_dec = (i_mode == bdag_pkg::MODE_PTR_MAIN_DEC);
  wire m_main = (i_mode == bdag_pkg::MODE_PTR_MAIN) || m_inc || m_dec;
  wire m_alt_a = (i_mode == bdag_pkg::MODE_PTR_ALT_A);
  wire m_alt_b = (i_mode == bdag_pkg::MODE_PTR_ALT_B);
  wire m_fmem = (i_mode == bdag_pkg::MODE_BIT_SPECIAL);
  wire m_pmem = (i_mode == bdag_pkg::MODE_BIT_PTR_PERIPH);
  wire m_hbit = (i_mode == bdag_pkg::MODE_BIT_PTR_HIGH);
  wire m_stack = (i_mode == bdag_pkg::MODE_STACK);

  wire i_mov = (i_instr == bdag_pkg::INS_MOVE);
  wire i_xch = (i_instr == bdag_pkg::INS_EXCHANGE);
  wire i_increment_skip_instr = (i_instr == bdag_pkg::INS_INCR_SKIP);
  wire i_in = (i_instr == bdag_pkg::INS_INPUT);
  wire i_out = (i_instr == bdag_pkg::INS_OUTPUT);
  wire i_cmp = (i_instr == bdag_pkg::INS_COMPARE_SKIP);
  wire i_bitop = (i_instr == bdag_pkg::INS_BIT_SET) || (i_instr == bdag_pkg::INS_BIT_CLEAR) ||
                 (i_instr == bdag_pkg::INS_SKIP_TRUE) || (i_instr == bdag_pkg::INS_SKIP_FALSE);
  wire i_bitlog = i_bitop || (i_instr == bdag_pkg::INS_BIT_LOGIC);

  wire [7:0] op_low = i_operand[7:0];
  wire [7:0] ptr_main = {i_ptr_high, i_ptr_low};

  // ***************************************************************
  // bank selection
  // ***************************************************************
  // with the flag clear the offset msb picks ram bank or peripheral bank
  wire [3:0] direct_bank = bank_bus.bank_enable_flag ? bank_bus.bank_select_reg :
                           (op_low[7] ? bdag_pkg::BANK_PERIPH : bdag_pkg::BANK_SRAM);

  // ***************************************************************
  // legality of mode versus instruction
  // ***************************************************************
  wire ok_direct = i_byte ? (i_mov || i_xch || i_in || i_out) && !op_low[0]
                          : (i_mov || i_xch || i_increment_skip_instr || i_in || i_out);
  wire ok_bit_dir = i_bitop;
  wire ok_main = !(i_byte && (m_inc || m_dec)); // byte forms have no auto step
  wire ok_alt = (i_mov || i_xch) && !i_byte;
  wire ok_fmem = i_bitlog && ((op_low[7:4] == bdag_pkg::FMEM_INTR_NIB) ||
                              (op_low[7:4] == bdag_pkg::FMEM_PORT_NIB));
  wire ok_pmem = i_bitlog && (i_operand[9:4] == bdag_pkg::PMEM_TOP);
  wire ok_hbit = i_bitlog;

  wire mode_ok = m_direct ? ok_direct :
                 m_bit_dir ? ok_bit_dir :
                 m_main ? ok_main :
                 (m_alt_a || m_alt_b) ? ok_alt :
                 m_fmem ? ok_fmem :
                 m_pmem ? ok_pmem :
                 m_hbit ? ok_hbit :
                 m_stack;

  // ***************************************************************
  // address formation
  // ***************************************************************
  // byte forms drop bit 0 so the pair is always even then odd
  wire [7:0] main_ofs = i_byte ? {ptr_main[7:1], 1'b0} : ptr_main;
  // all ten operand bits sit above the two low pointer bits
  wire [11:0] pmem_addr = {i_operand, i_ptr_low[1:0]};

  wire [11:0] calc_addr =
    (m_direct || m_bit_dir) ? {direct_bank, op_low} :
    m_main ? {bank_bus.active_bank, main_ofs} :
    m_alt_a ? {bdag_pkg::BANK_SRAM, i_alt_pointer_pair_a} :
    m_alt_b ? {bdag_pkg::BANK_SRAM, i_alt_pointer_pair_b} :
    m_fmem ? {bdag_pkg::BANK_PERIPH, op_low} :
    m_pmem ? pmem_addr :
    m_hbit ? {bank_bus.active_bank, i_ptr_high, op_low[3:0]} :
    {bdag_pkg::BANK_SRAM, i_stack_ptr};

  // second nibble of a byte access sits one address higher
  wire [11:0] calc_pair = {calc_addr[11:1], 1'b1};

  wire [1:0] calc_bit = m_pmem ? i_ptr_low[1:0] : i_bit;

  bdag_pkg::bdag_region_e region;

  bdag_region_dec u_region (
    .i_addr(calc_addr),
    .o_region(region)
  );

  // ***************************************************************
  // nonvolatile access restriction
  // ***************************************************************
  // only byte move and exchange via direct or main pointer, byte compare-skip via main pointer only
  wire nv_form_ok = i_byte && (i_mov || i_xch || i_cmp) &&
                    ((m_direct && !i_cmp) || (i_instr != bdag_pkg::INS_OTHER &&
                     (i_mode == bdag_pkg::MODE_PTR_MAIN)));
  wire nv_bad = (region == bdag_pkg::REG_NV) && !nv_form_ok;

  wire accept = i_req && mode_ok && !nv_bad;
  wire refuse = i_req && !accept;

  // ***************************************************************
  // post step of the low pointer
  // ***************************************************************
  // the step is handed out with the address; the core writes it after the access
  wire step = accept && (m_inc || m_dec);
  wire [3:0] next_low = m_inc ? i_ptr_low + bdag_pkg::ONE_NIB
                              : i_ptr_low - bdag_pkg::ONE_NIB;

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  // refused or unpopulated accesses still answer, arrays key off region
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr_valid <= 1'b0;
      o_refused <= 1'b0;
      o_ptr_low_wr <= 1'b0;
    end else begin
      o_addr_valid <= accept;
      o_refused <= refuse;
      o_ptr_low_wr <= step;
    end
  end

  // address payload, held between accesses
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr <= '0;
      o_addr_pair <= '0;
      o_pair <= 1'b0;
      o_bit_num <= '0;
      o_region <= bdag_pkg::REG_NONE;
      o_ptr_low_next <= '0;
    end else if (accept) begin
      o_addr <= calc_addr;
      o_addr_pair <= calc_pair;
      o_pair <= i_byte && (m_direct || m_main);
      o_bit_num <= calc_bit;
      o_region <= region;
      o_ptr_low_next <= step ? next_low : i_ptr_low;
    end
  end

  // mirrors of the bank state for the core and debug
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bank_enable_flag <= bdag_pkg::RST_FLAG;
      o_bank_select_reg <= bdag_pkg::RST_SEL;
    end else begin
      o_bank_enable_flag <= bank_bus.bank_enable_flag;
      o_bank_select_reg <= bank_bus.bank_select_reg;
    end
  end

endmodule : bdag_top

/* File: dv/bdag_mem_model.sv */
`timescale 1ns/10ps
// ***************************************************************
// data memory stand-in behind the address generator
// ***************************************************************
module bdag_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [1:0] i_region,
  output logic [7:0] o_nv_hits,
  output logic [3:0] o_rd_data
);
  // count nonvolatile hits; unmapped reads flip so nobody relies on them
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_nv_hits <= 8'h00;
      o_rd_data <= 4'h0;
    end else if (i_valid) begin
      if (i_region == bdag_pkg::REG_NV) begin
        o_nv_hits <= o_nv_hits + 8'h01;
      end
      o_rd_data <= (i_region == bdag_pkg::REG_NONE) ? ~o_rd_data : 4'h5;
    end
  end
endmodule : bdag_mem_model

/* File: dv/bdag_top_assertions.sv */
`timescale 1ns/10ps
module bdag_top_chk (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic [3:0] i_mode,
  input wire logic [3:0] i_instr,
  input wire logic i_byte,
  input wire logic [9:0] i_operand,
  input wire logic [1:0] i_bit,
  input wire logic [3:0] i_ptr_high,
  input wire logic [3:0] i_ptr_low,
  input wire logic [7:0] i_alt_pointer_pair_a,
  input wire logic [7:0] i_stack_ptr,
  input wire logic i_sel_load,
  input wire logic [3:0] i_sel_val,
  input wire logic o_addr_valid,
  input wire logic [11:0] o_addr,
  input wire logic o_pair,
  input wire logic [11:0] o_addr_pair,
  input wire logic [1:0] o_bit_num,
  input wire logic o_refused,
  input wire logic o_ptr_low_wr,
  input wire logic [3:0] o_ptr_low_next,
  input wire logic o_sel_refused,
  input wire logic o_bank_enable_flag,
  input wire logic [3:0] o_bank_select_reg
);
  // ***************************************************************
  // access checks
  // ***************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // mirrors lag one cycle, so sampled one edge later they show the bank in use
  wire nib_mv = i_req && !i_byte && i_instr == bdag_pkg::INS_MOVE;
  wire hi_ok = i_ptr_high[3:2] != 2'b00;
  wire [3:0] bank_used = o_bank_enable_flag ? o_bank_select_reg : 4'h0;

  property p_answer; i_req |=> o_addr_valid ^ o_refused; endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");
  property p_direct; nib_mv && i_mode == bdag_pkg::MODE_DIRECT && i_operand[7:6] != 2'b00
    |=> o_addr_valid && o_addr == {o_bank_enable_flag ? o_bank_select_reg
    : {4{$past(i_operand[7])}}, $past(i_operand[7:0])}; endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_main; nib_mv && i_mode == bdag_pkg::MODE_PTR_MAIN && hi_ok
    |=> o_addr == {bank_used, $past(i_ptr_high), $past(i_ptr_low)}; endproperty
  a_main: assert property (p_main) else $error("main pointer address wrong");
  property p_inc; nib_mv && i_mode == bdag_pkg::MODE_PTR_MAIN_INC && hi_ok
    |=> o_ptr_low_wr && o_ptr_low_next == $past(i_ptr_low) + 4'h1; endproperty
  a_inc: assert property (p_inc) else $error("post increment wrong");
  property p_dec; nib_mv && i_mode == bdag_pkg::MODE_PTR_MAIN_DEC && hi_ok
    |-> ##1 o_ptr_low_wr && o_ptr_low_next == $past(i_ptr_low) - 4'h1; endproperty
  a_dec: assert property (p_dec) else $error("post decrement wrong");
  property p_alt; nib_mv && i_mode == bdag_pkg::MODE_PTR_ALT_A
    |=> o_addr == {4'h0, $past(i_alt_pointer_pair_a)}; endproperty
  a_alt: assert property (p_alt) else $error("alternate pointer left bank 0");
  property p_alt_ref; i_req && i_instr == bdag_pkg::INS_INCR_SKIP
    && i_mode inside {bdag_pkg::MODE_PTR_ALT_A, bdag_pkg::MODE_PTR_ALT_B} |=> o_refused;
  endproperty
  a_alt_ref: assert property (p_alt_ref) else $error("alternate pointer misuse taken");
  property p_stack; i_req && i_mode == bdag_pkg::MODE_STACK
    |=> o_addr_valid && o_addr == {4'h0, $past(i_stack_ptr)}; endproperty
  a_stack: assert property (p_stack) else $error("stack address wrong");
  property p_fmem; i_req && i_mode == bdag_pkg::MODE_BIT_SPECIAL
    && i_instr == bdag_pkg::INS_BIT_SET && i_operand[7:4] == 4'hb
    |=> o_addr == {8'hfb, $past(i_operand[3:0])} && o_bit_num == $past(i_bit); endproperty
  a_fmem: assert property (p_fmem) else $error("special bit address wrong");
  property p_pmem; i_req && i_mode == bdag_pkg::MODE_BIT_PTR_PERIPH
    && i_instr == bdag_pkg::INS_BIT_CLEAR && i_operand[9:4] == 6'h3f
    |=> o_addr == {$past(i_operand), $past(i_ptr_low[1:0])}
    && o_bit_num == $past(i_ptr_low[1:0]); endproperty
  a_pmem: assert property (p_pmem) else $error("pointer bit address wrong");
  property p_odd; i_req && i_byte && i_mode == bdag_pkg::MODE_DIRECT
    && i_instr == bdag_pkg::INS_MOVE && i_operand[0] |=> o_refused && !o_addr_valid;
  endproperty
  a_odd: assert property (p_odd) else $error("odd byte offset taken");
  property p_pair; i_req && i_byte && i_mode == bdag_pkg::MODE_PTR_MAIN
    && i_instr == bdag_pkg::INS_MOVE && hi_ok
    |=> o_pair && !o_addr[0] && o_addr_pair == {o_addr[11:1], 1'b1}; endproperty
  a_pair: assert property (p_pair) else $error("byte pair wrong");
  property p_bitdir; i_req && i_mode == bdag_pkg::MODE_BIT_DIRECT
    && !(i_instr inside {[bdag_pkg::INS_BIT_SET : bdag_pkg::INS_SKIP_FALSE]}) |=> o_refused;
  endproperty
  a_bitdir: assert property (p_bitdir) else $error("bit direct misuse taken");
  // a refused select leaves the mirror where it was
  property p_sel; i_sel_load && !(i_sel_val inside {4'h0, 4'h4, 4'hf})
    |=> o_sel_refused ##1 $stable(o_bank_select_reg); endproperty
  a_sel: assert property (p_sel) else $error("bad bank select taken");
endmodule : bdag_top_chk

bind bdag_top bdag_top_chk u_chk (.i_sys_clk, .i_nrst, .i_req, .i_mode, .i_instr, .i_byte,
  .i_operand, .i_bit, .i_ptr_high, .i_ptr_low, .i_alt_pointer_pair_a, .i_stack_ptr,
  .i_sel_load, .i_sel_val, .o_addr_valid, .o_addr, .o_pair, .o_addr_pair, .o_bit_num,
  .o_refused, .o_ptr_low_wr, .o_ptr_low_next, .o_sel_refused, .o_bank_enable_flag,
  .o_bank_select_reg);

/* File: dv/bdag_top_tb.sv */
`timescale 1ns/10ps
module bdag_top_tb;
  // ***************************************************************
  // stimulus and wiring
  // ***************************************************************
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_req = 1'b0;
  logic [3:0] i_mode = 4'h0;
  logic [3:0] i_instr = 4'h0;
  logic i_byte = 1'b0;
  logic [9:0] i_operand = 10'h000;
  logic [3:0] i_ptr_high = 4'h0;
  logic [3:0] i_ptr_low = 4'h0;
  logic [3:0] i_sel_val = 4'h0;
  logic [6:0] c = 7'h00;
  logic iv = 1'b0;
  logic o_addr_valid, o_pair, o_refused, o_ptr_low_wr, o_sel_refused, o_bank_enable_flag;
  logic [11:0] o_addr, o_addr_pair;
  logic [1:0] o_bit_num, o_region;
  logic [3:0] o_ptr_low_next, o_bank_select_reg, rd_data;
  logic [7:0] nv_hits;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  // vector flag value from the interrupt table is driven by iv
  bdag_top #(.FLAG_DEPTH(8)) dut (.i_sys_clk, .i_nrst, .i_req, .i_mode, .i_instr, .i_byte,
    .i_operand, .i_bit(2'h2), .i_ptr_high, .i_ptr_low, .i_alt_pointer_pair_a(8'h5a),
    .i_alt_pointer_pair_b(8'h6b), .i_stack_ptr(8'h64), .i_flag_set(c[0]), .i_flag_clr(c[1]),
    .i_sel_load(c[2]), .i_sel_val, .i_call(c[3]), .i_ret(c[4]), .i_int_entry(c[5]),
    .i_int_flag_val(iv), .i_int_ret(c[6]), .o_addr_valid, .o_addr, .o_pair, .o_addr_pair,
    .o_bit_num, .o_region, .o_refused, .o_ptr_low_wr, .o_ptr_low_next, .o_sel_refused,
    .o_bank_enable_flag, .o_bank_select_reg);
  bdag_mem_model u_mem (.i_sys_clk, .i_nrst, .i_valid(o_addr_valid), .i_region(o_region),
    .o_nv_hits(nv_hits), .o_rd_data(rd_data));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // one request cycle; answer is settled one edge later
  task automatic rq(input logic [3:0] m, input logic [3:0] ins, input logic b,
                    input logic [9:0] op, input logic [3:0] h, input logic [3:0] l);
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_mode <= m;
    i_instr <= ins;
    i_byte <= b;
    i_operand <= op;
    i_ptr_high <= h;
    i_ptr_low <= l;
    @(posedge i_sys_clk);
    i_req <= 1'b0;
    #1;
  endtask : rq

  task automatic ok(input logic [11:0] a, input logic [1:0] r);
    chk("valid", 12'h001, {11'h0, o_addr_valid});
    chk("addr", a, o_addr);
    chk("region", {10'h0, r}, {10'h0, o_region});
  endtask : ok

  task automatic refd;
    chk("refused", 12'h001, {11'h0, o_refused});
  endtask : refd

  // control pulse; waits so that the mirrors have caught up
  task automatic pl(input int k, input logic [3:0] v);
    @(posedge i_sys_clk);
    c <= 7'h01 << k;
    i_sel_val <= v;
    @(posedge i_sys_clk);
    c <= 7'h00;
    @(posedge i_sys_clk);
    #1;
  endtask : pl

  task automatic fl(input logic f, input logic [3:0] s);
    chk("flag", {11'h0, f}, {11'h0, o_bank_enable_flag});
    chk("select", {8'h0, s}, {8'h0, o_bank_select_reg});
  endtask : fl

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_direct;
    fl(1'b0, 4'h0);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b0, 10'h085, 4'h0, 4'h0);
    ok(12'hf85, 2'h3);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_EXCHANGE, 1'b0, 10'h012, 4'h0, 4'h0);
    ok(12'h012, 2'h1);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b1, 10'h033, 4'h0, 4'h0);
    refd();
    for (int k = 0; k < 9; k++) begin
      rq(k < 5 ? bdag_pkg::MODE_DIRECT : bdag_pkg::MODE_BIT_DIRECT, 4'(k), 1'b0, 10'h0f3,
         4'h0, 4'h0);
      ok(12'hff3, 2'h3);
    end
    rq(bdag_pkg::MODE_BIT_DIRECT, bdag_pkg::INS_MOVE, 1'b0, 10'h0f3, 4'h0, 4'h0);
    refd();
  endtask : t_direct

  task automatic t_bank;
    pl(0, 4'h0);
    pl(2, 4'h4);
    fl(1'b1, 4'h4);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b1, 10'h010, 4'h0, 4'h0);
    ok(12'h410, 2'h2);
    chk("pair", 12'h411, o_addr_pair);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b0, 10'h010, 4'h0, 4'h0);
    refd();
    rq(bdag_pkg::MODE_PTR_MAIN, bdag_pkg::INS_COMPARE_SKIP, 1'b1, 10'h0, 4'h1, 4'h5);
    ok(12'h414, 2'h2);
    pl(2, 4'h5);
    fl(1'b1, 4'h4);
    pl(2, 4'hf);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b0, 10'h020, 4'h0, 4'h0);
    ok(12'hf20, 2'h0);
    rq(bdag_pkg::MODE_BIT_PTR_HIGH, bdag_pkg::INS_BIT_SET, 1'b0, 10'h005, 4'h3, 4'h0);
    ok(12'hf35, 2'h0);
    chk("bit", 12'h002, {10'h0, o_bit_num});
    rq(bdag_pkg::MODE_STACK, bdag_pkg::INS_STACK_OP, 1'b0, 10'h0, 4'h0, 4'h0);
    ok(12'h064, 2'h1);
    rq(bdag_pkg::MODE_PTR_ALT_B, bdag_pkg::INS_EXCHANGE, 1'b0, 10'h0, 4'h0, 4'h0);
    ok(12'h06b, 2'h1);
    rq(bdag_pkg::MODE_PTR_ALT_A, bdag_pkg::INS_MOVE, 1'b0, 10'h0, 4'h0, 4'h0);
    ok(12'h05a, 2'h1);
    rq(bdag_pkg::MODE_PTR_ALT_A, bdag_pkg::INS_INCR_SKIP, 1'b0, 10'h0, 4'h0, 4'h0);
    refd();
  endtask : t_bank

  // save and restore of the flag around a call and around interrupts, one level deep at a time
  task automatic t_nest;
    pl(3, 4'h0);
    pl(1, 4'h0);
    fl(1'b0, 4'hf);
    rq(bdag_pkg::MODE_DIRECT, bdag_pkg::INS_MOVE, 1'b0, 10'h045, 4'h0, 4'h0);
    ok(12'h045, 2'h1);
    pl(4, 4'h0);
    fl(1'b1, 4'hf);
    pl(5, 4'h0);
    fl(1'b0, 4'hf);
    pl(6, 4'h0);
    fl(1'b1, 4'hf);
    // vector value one with the flag clear, so the load is visible
    pl(1, 4'h0);
    @(posedge i_sys_clk);
    iv <= 1'b1;
    pl(5, 4'h0);
    fl(1'b1, 4'hf);
    pl(6, 4'h0);
    fl(1'b0, 4'hf);
  endtask : t_nest

  task automatic t_ptr;
    pl(1, 4'h0);
    rq(bdag_pkg::MODE_PTR_MAIN_INC, bdag_pkg::INS_MOVE, 1'b0, 10'h0, 4'h4, 4'hf);
    ok(12'h04f, 2'h1);
    chk("low next", 12'h000, {8'h0, o_ptr_low_next});
    rq(bdag_pkg::MODE_PTR_MAIN, bdag_pkg::INS_MOVE, 1'b0, 10'h0, 4'h6, 4'h5);
    ok(12'h065, 2'h1);
    rq(bdag_pkg::MODE_PTR_MAIN_DEC, bdag_pkg::INS_MOVE, 1'b0, 10'h0, 4'h5, 4'h0);
    chk("low next", 12'h00f, {8'h0, o_ptr_low_next});
    rq(bdag_pkg::MODE_PTR_MAIN, bdag_pkg::INS_MOVE, 1'b1, 10'h0, 4'h7, 4'h9);
    ok(12'h078, 2'h1);
    rq(bdag_pkg::MODE_BIT_SPECIAL, bdag_pkg::INS_BIT_SET, 1'b0, 10'h0b3, 4'h0, 4'h0);
    ok(12'hfb3, 2'h3);
    rq(bdag_pkg::MODE_BIT_SPECIAL, bdag_pkg::INS_BIT_SET, 1'b0, 10'h053, 4'h0, 4'h0);
    refd();
    rq(bdag_pkg::MODE_BIT_PTR_PERIPH, bdag_pkg::INS_BIT_CLEAR, 1'b0, 10'h3f9, 4'h0, 4'h6);
    ok(12'hfe6, 2'h3);
    chk("nv hits", 12'h002, {4'h0, nv_hits});
  endtask : t_ptr

  // ***************************************************************
  // run control
  // ***************************************************************
  // ceiling is far above the roughly one hundred cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    #1;
    t_direct();
    t_bank();
    t_nest();
    t_ptr();
    conclude();
  end
endmodule : bdag_top_tb
